// ---- design/fan_pwm_pkg.sv ----
// Constants shared by the fan drive duty-control block
package fan_pwm_pkg;
    // Drive level register
    localparam int LEVEL_W = 4;
    localparam logic [3:0] LEVEL_RESET = 4'h2;
    // Oscillator ticks per PWM period; chosen so every step is exact
    localparam int PERIOD_TICKS = 150;
    localparam int CNT_W = 8;
    localparam logic [7:0] MIN_ON_TICKS = 8'h2D;
    localparam logic [7:0] STEP_TICKS = 8'h07;
    // Analog input scale, millivolts
    localparam int MV_W = 12;
    localparam logic [11:0] TEMP_LOW_MV = 12'h654;
    localparam logic [11:0] TEMP_HIGH_MV = 12'hA28;
    // Ticks gained per 28 mV above the low point (105 ticks over 980 mV)
    localparam logic [7:0] MV_SCALE_NUM = 8'h03;
    localparam logic [7:0] MV_SCALE_DEN = 8'h1C;
    // Identification values; arbitrary
    localparam logic [7:0] MAKER_CODE_VAL = 8'hA5;
    localparam logic [1:0] VARIANT_CODE_VAL = 2'h3;
    // Cycles after reset release before the open pin is trusted
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_RUN = 2'b01
    } boot_state_t;
endpackage

// ---- design/fan_pwm_duty_control.sv ----
// Fan drive PWM with register or analog duty source and identity codes
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// What this block does
// - A 4-bit read/write drive level register selects the output duty.
// - Code 0 gives 30% duty and each step adds 4.67%, reaching 100% at 15.
// - In analog mode with the input found open, code 2 (39.33%) is used.
// - The drive level register is the host's path for commanding speed.
// - An 8-bit maker code reads back a fixed value that writes cannot alter.
// - A 2-bit variant code tells the base part from the fault-signalling one.
// - In analog mode 1.62 V gives 30% duty and 2.6 V gives 100%, linearly.
// - Source select set takes duty from the register, clear from the input.
// - After power-up the open input state is captured into a status flag.
module fan_pwm_duty_control
    import fan_pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level_wr_en,
    input wire logic [LEVEL_W-1:0] level_wr_data,
    input wire logic drive_source_select,
    input wire logic [MV_W-1:0] temperature_voltage_input,
    input wire logic input_open_pin,
    input wire logic oscillator_capacitor_pin,
    output logic [LEVEL_W-1:0] fan_drive_level,
    output logic [7:0] maker_code,
    output logic [1:0] variant_code,
    output logic input_open_flag,
    output logic fan_drive_output
);

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [MV_W-1:0] temp_meta;
    logic [MV_W-1:0] temp_sync;
    logic [MV_W-1:0] temp_prev;
    logic [MV_W-1:0] temp_stable;
    logic open_meta;
    logic open_sync;
    logic osc_meta;
    logic osc_sync;
    logic osc_last;

    // Two flops per bit keep metastability away from the duty logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            temp_meta <= '0;
            temp_sync <= '0;
        end else begin
            temp_meta <= temperature_voltage_input;
            temp_sync <= temp_meta;
        end
    end

    // A multi-bit word can tear while the converter updates, so a new
    // value is only taken once two samples in a row agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            temp_prev <= '0;
            temp_stable <= '0;
        end else begin
            temp_prev <= temp_sync;
            if (temp_sync == temp_prev) begin
                temp_stable <= temp_sync;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            open_meta <= 1'b0;
            open_sync <= 1'b0;
        end else begin
            open_meta <= input_open_pin;
            open_sync <= open_meta;
        end
    end

    // Only rising edges of the oscillator count; osc_last keeps the
    // previous synchronised level for the edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_last <= 1'b0;
        end else begin
            osc_meta <= oscillator_capacitor_pin;
            osc_sync <= osc_meta;
            osc_last <= osc_sync;
        end
    end

    logic osc_tick;
    assign osc_tick = osc_sync & ~osc_last;

    //////////////////////////////////////////////////////////////////////////
    // Registers and identity
    // Back-to-back writes are allowed; the last one wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fan_drive_level <= LEVEL_RESET;
        end else if (level_wr_en) begin
            fan_drive_level <= level_wr_data;
        end
    end

    // Identity outputs read zero in reset, then fixed codes; no write port reaches them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            maker_code <= 8'h00;
            variant_code <= 2'h0;
        end else begin
            maker_code <= MAKER_CODE_VAL;
            variant_code <= VARIANT_CODE_VAL;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Power-up check of the open input
    boot_state_t boot_state;
    logic [1:0] settle_cnt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_state <= ST_SETTLE;
            settle_cnt <= 2'h0;
            input_open_flag <= 1'b0;
        end else begin
            case (boot_state)
                ST_SETTLE: begin
                    // Wait until the synchroniser holds a real pin sample
                    if (settle_cnt == SETTLE_CYCLES) begin
                        input_open_flag <= open_sync;
                        boot_state <= ST_RUN;
                    end else begin
                        settle_cnt <= settle_cnt + 2'h1;
                    end
                end
                ST_RUN: begin
                    // Power-up capture only; pin changes wait for reset
                    boot_state <= ST_RUN;
                end
                default: begin
                    // Unreachable codes restart the capture
                    boot_state <= ST_SETTLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Duty selection
    // Code 15 gives a full period of on time, so the output stays high
    function automatic logic [CNT_W-1:0] code_ticks(
        input logic [LEVEL_W-1:0] code
    );
        code_ticks = MIN_ON_TICKS + STEP_TICKS * {4'h0, code};
    endfunction

    logic [MV_W-1:0] temp_above;
    // Widest product is 980 mV times 3, well inside these 20 bits
    logic [MV_W+7:0] temp_scaled;
    logic [CNT_W-1:0] analog_ticks;
    logic [CNT_W-1:0] next_on_ticks;

    // Below the low point the duty floors at 30%; at or above the high
    // point it saturates at a full period
    always_comb begin
        temp_above = '0;
        if (temp_stable >= TEMP_HIGH_MV) begin
            temp_above = TEMP_HIGH_MV - TEMP_LOW_MV;
        end else if (temp_stable > TEMP_LOW_MV) begin
            temp_above = temp_stable - TEMP_LOW_MV;
        end
        temp_scaled = ({8'h00, temp_above} * {12'h000, MV_SCALE_NUM})
            / {12'h000, MV_SCALE_DEN};
        analog_ticks = MIN_ON_TICKS + temp_scaled[CNT_W-1:0];
    end

    // The register path wins whenever the host owns the duty; the
    // open-input default only applies in analog mode
    always_comb begin
        if (drive_source_select) begin
            next_on_ticks = code_ticks(fan_drive_level);
        end else if (input_open_flag) begin
            next_on_ticks = code_ticks(LEVEL_RESET);
        end else begin
            next_on_ticks = analog_ticks;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // PWM timebase; duty is latched per period so edges never tear
    // Ticks come only from real oscillator edges, never from clk alone
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] on_ticks;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_cnt <= '0;
            on_ticks <= code_ticks(LEVEL_RESET);
        end else if (osc_tick) begin
            if (period_cnt == CNT_W'(PERIOD_TICKS - 1)) begin
                period_cnt <= '0;
                on_ticks <= next_on_ticks;
            end else begin
                period_cnt <= period_cnt + 8'h01;
            end
        end
    end

    // Output lags the counter by one clock; resolution is one tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fan_drive_output <= 1'b0;
        end else begin
            fan_drive_output <= (period_cnt < on_ticks);
        end
    end

endmodule

// ---- verif/osc_model.sv ----
// External capacitor oscillator: free-running square wave
`timescale 1ns/100ps
module osc_model #(
    parameter int HALF = 2
) (
    input wire logic clk,
    output logic osc
);
    logic q = 1'b0;
    int cnt = 0;
    assign osc = q;
    // Each level lasts HALF clocks so the block can sync every edge
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            q <= ~q;
        end
    end
endmodule

// ---- verif/fan_pwm_monitor.sv ----
// Port checks for the fan drive duty block
`timescale 1ns/100ps
module fan_pwm_monitor
    import fan_pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level_wr_en,
    input wire logic [LEVEL_W-1:0] level_wr_data,
    input wire logic [LEVEL_W-1:0] fan_drive_level,
    input wire logic [7:0] maker_code,
    input wire logic [1:0] variant_code,
    input wire logic input_open_flag,
    input wire logic fan_drive_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    maker_fixed_a: assert property (
        $past(rst_n) |-> maker_code == MAKER_CODE_VAL) else $error("maker");
    variant_fixed_a: assert property (
        $past(rst_n) |-> variant_code == VARIANT_CODE_VAL) else $error("var");
    level_reset_a: assert property (
        $rose(rst_n) |-> fan_drive_level == LEVEL_RESET) else $error("rst");
    level_write_a: assert property (
        level_wr_en |=> fan_drive_level == $past(level_wr_data))
        else $error("write");
    level_hold_a: assert property (
        !level_wr_en |=> $stable(fan_drive_level)) else $error("hold");
    flag_hold_a: assert property (
        rst_n [*6] |=> $stable(input_open_flag)) else $error("flag");
    high_run_a: assert property (
        $rose(fan_drive_output) |-> fan_drive_output [*4]) else $error("hi");
    low_run_a: assert property (
        $fell(fan_drive_output) |-> !fan_drive_output [*4]) else $error("lo");
endmodule
bind fan_pwm_duty_control fan_pwm_monitor mon_u (.clk, .rst_n, .level_wr_en,
    .level_wr_data, .fan_drive_level, .maker_code, .variant_code,
    .input_open_flag, .fan_drive_output);

// ---- verif/tb_top.sv ----
// Self-checking bench for the fan drive duty block
`timescale 1ns/100ps
module tb_top;
    import fan_pwm_pkg::*;
    logic clk = 0, rst_n = 0, level_wr_en = 0, drive_source_select = 0;
    logic input_open_pin = 1, oscillator_capacitor_pin, input_open_flag;
    logic [3:0] level_wr_data = 0, fan_drive_level;
    logic [11:0] temperature_voltage_input = 0;
    logic [7:0] maker_code;
    logic [1:0] variant_code;
    logic fan_drive_output;
    int fail_count = 0, samples_checked = 0, n, v;
    int corners[4] = '{1000, 1620, 2600, 4000};
    initial forever #4 clk = ~clk;
    osc_model #(.HALF(2)) osc_u (.clk, .osc(oscillator_capacitor_pin));
    fan_pwm_duty_control DUT (
        .clk(clk),
        .rst_n(rst_n),
        .level_wr_en(level_wr_en),
        .level_wr_data(level_wr_data),
        .drive_source_select(drive_source_select),
        .temperature_voltage_input(temperature_voltage_input),
        .input_open_pin(input_open_pin),
        .oscillator_capacitor_pin(oscillator_capacitor_pin),
        .fan_drive_level(fan_drive_level),
        .maker_code(maker_code),
        .variant_code(variant_code),
        .input_open_flag(input_open_flag),
        .fan_drive_output(fan_drive_output)
    );
    //////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One tick is four clocks, so expected high clocks are ticks times four
    function automatic logic [15:0] on_mv(input int x);
        int c;
        c = x < 1620 ? 1620 : (x > 2600 ? 2600 : x);
        return 16'((45 + (c - 1620) * 3 / 28) * 4);
    endfunction
    task hold_reset(input logic pin);
        @(posedge clk);
        rst_n <= 0;
        input_open_pin <= pin;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (6) @(posedge clk);
        check(input_open_flag, pin);
    endtask
    task put(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk);
        level_wr_en <= 1;
        level_wr_data <= a;
        @(posedge clk);
        level_wr_data <= b;
        @(posedge clk);
        level_wr_en <= 0;
        @(posedge clk);
        check(fan_drive_level, b);
    endtask
    // Two periods let a new duty reach a period start, then count one period
    task duty(input logic [15:0] exp);
        repeat (1200) @(posedge clk);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            n += fan_drive_output;
        end
        check(n[15:0], exp);
    endtask
    task tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h2a27));
        hold_reset(1'b1);
        check(maker_code, MAKER_CODE_VAL);
        check(variant_code, VARIANT_CODE_VAL);
        check(fan_drive_level, LEVEL_RESET);
        duty(16'(59 * 4));
        drive_source_select <= 1;
        for (int i = 0; i < 16; i++) begin
            put(4'($urandom), 4'(i));
            duty(16'((45 + 7 * i) * 4));
        end
        drive_source_select <= 0;
        hold_reset(1'b0);
        check(fan_drive_level, LEVEL_RESET);
        for (int k = 0; k < 8; k++) begin
            v = k < 4 ? corners[k] : 1500 + $urandom % 1200;
            temperature_voltage_input <= 12'(v);
            duty(on_mv(v));
        end
        put(4'h9, 4'h0);
        drive_source_select <= 1;
        duty(16'(45 * 4));
        tally_and_finish;
    end
endmodule
